// *** design/flash_reset_defs.vh ***
`ifndef FLASH_RESET_DEFS_VH
`define FLASH_RESET_DEFS_VH

// instruction codes
`define OP_RESET_ENABLE   8'h66
`define OP_RESET          8'h99
`define OP_WRITE_ENABLE   8'h06
`define OP_VOL_WR_ENABLE  8'h50
`define OP_WRITE_STATUS   8'h01

// continuous 0-4-4 mode bits
`define MODE_BITS_STAY    8'hA5
`define MODE_BITS_EXIT    8'h00

// interface width codes
`define WIDTH_SINGLE      2'h0
`define WIDTH_DUAL        2'h1
`define WIDTH_QUAD        2'h2

// parameter table doubleword fields
`define PT_ENTER_4B       8'h80
`define PT_EXIT_4B        10'h300
`define PT_SOFT_RESET     6'h30
`define PT_RFU_BIT7       1'h1
`define PT_SR1_WREN       7'h68

// status register 1 writable field
`define SR1_WR_MSB        7
`define SR1_WR_LSB        2

// reset timing
`define CLK_PERIOD_NS     10
`define T_RST_NS          10000
`define T_RST_CYCLES      (`T_RST_NS / `CLK_PERIOD_NS)

`endif

// *** design/spi_byte_rx.v ***
`timescale 1ns/10ps
`include "flash_reset_defs.vh"

module spi_byte_rx
(
	// clock and reset
	input  wire       i_mclk,
	input  wire       i_rst,
	// filtered link
	input  wire       i_frame,
	input  wire       i_sclk_rise,
	input  wire [1:0] i_width,
	input  wire [3:0] i_io,
	// assembled bytes
	output reg        o_byte_stb,
	output reg  [7:0] o_byte
);

	reg [7:0] shift_reg;
	reg [7:0] shift_next;
	reg [3:0] bits_reg;
	reg [3:0] bits_next;

	// shift 1, 2 or 4 bits per clock, msb first
	always @*
	begin
		case (i_width)
			`WIDTH_DUAL:
			begin
				shift_next = {shift_reg[5:0], i_io[1:0]};
				bits_next  = bits_reg + 4'h2;
			end
			`WIDTH_QUAD:
			begin
				shift_next = {shift_reg[3:0], i_io};
				bits_next  = bits_reg + 4'h4;
			end
			default:
			begin
				shift_next = {shift_reg[6:0], i_io[0]};
				bits_next  = bits_reg + 4'h1;
			end
		endcase
	end

	// partial byte is dropped when the frame ends
	always @(posedge i_mclk)
	begin
		if (i_rst || !i_frame)
		begin
			shift_reg  <= 8'h00;
			bits_reg   <= 4'h0;
			o_byte_stb <= 1'b0;
			o_byte     <= 8'h00;
		end
		else if (i_sclk_rise)
		begin
			if (bits_next >= 4'h8)
			begin
				o_byte_stb <= 1'b1;
				o_byte     <= shift_next;
				bits_reg   <= 4'h0;
				shift_reg  <= 8'h00;
			end
			else
			begin
				o_byte_stb <= 1'b0;
				bits_reg   <= bits_next;
				shift_reg  <= shift_next;
			end
		end
		else
			o_byte_stb <= 1'b0;
	end

endmodule // spi_byte_rx

// *** design/flash_reset_ctrl.v ***
// Function
// - table reports entering four-byte addressing as not supported.
// - table reports every four-byte exit method as not supported.
// - reset happens only after reset-enable then reset, in order.
// - reset pair accepted on one, two or four lines per width.
// - status register 1 loads from its non-volatile copy at power-up.
// - write-enable precedes a status write to the non-volatile copy.
// - volatile write-enable makes next status write touch volatile copy only.
// - about ten microseconds of reset, no command accepted meanwhile.
// - mode bits of zero end 0-4-4 mode when the read finishes.
`timescale 1ns/10ps
`include "flash_reset_defs.vh"

module flash_reset_ctrl
#(
	parameter RST_CYCLES = `T_RST_CYCLES
)
(
	// clock and reset
	input  wire        i_mclk,
	input  wire        i_rst,
	// spi pins
	input  wire        i_sclk,
	input  wire        i_cs_n,
	input  wire [3:0]  i_io,
	// device context
	input  wire [1:0]  i_width,
	input  wire [7:0]  i_nv_sr1,
	input  wire        i_mode_bits_stb,
	input  wire [7:0]  i_mode_bits,
	input  wire        i_read_done,
	// results
	output reg  [31:0] o_param_dword,
	output reg  [7:0]  o_sr1,
	output reg         o_wel,
	output reg         o_vwel,
	output reg         o_nv_write,
	output reg  [7:0]  o_nv_data,
	output reg         o_soft_reset,
	output reg         o_busy,
	output reg         o_xip,
	output reg         o_cmd_stb,
	output reg  [7:0]  o_cmd_code
);

	localparam ST_LOAD = 2'h0;
	localparam ST_IDLE = 2'h1;
	localparam ST_RST  = 2'h2;

	// pin idle levels: cs_n high, the rest low, so no false frame after reset
	localparam [5:0] PIN_IDLE = 6'h10;

	// synchronisers: sclk, cs_n, io[3:0]
	wire [5:0] pin_raw = {i_sclk, i_cs_n, i_io};
	reg  [5:0] s1_reg;
	reg  [5:0] s2_reg;
	reg  [5:0] s3_reg;
	reg  [5:0] filt_reg;

	genvar g;
	generate
		for (g = 0; g < 6; g = g + 1)
		begin : g_sync
			// a change counts only once stages two and three agree
			always @(posedge i_mclk)
			begin
				if (i_rst)
				begin
					s1_reg[g]   <= PIN_IDLE[g];
					s2_reg[g]   <= PIN_IDLE[g];
					s3_reg[g]   <= PIN_IDLE[g];
					filt_reg[g] <= PIN_IDLE[g];
				end
				else
				begin
					s1_reg[g] <= pin_raw[g];
					s2_reg[g] <= s1_reg[g];
					s3_reg[g] <= s2_reg[g];
					if (s2_reg[g] == s3_reg[g])
						filt_reg[g] <= s3_reg[g];
				end
			end
		end
	endgenerate

	reg        sclk_d_reg;
	reg        frame_d_reg;
	wire       frame     = ~filt_reg[4];
	wire       sclk_rise = filt_reg[5] & ~sclk_d_reg;
	wire       frame_end = frame_d_reg & ~frame;
	wire       byte_stb;
	wire [7:0] byte_val;

	spi_byte_rx u_rx
	(
		.i_mclk      (i_mclk),
		.i_rst       (i_rst),
		.i_frame     (frame),
		.i_sclk_rise (sclk_rise),
		.i_width     (i_width),
		.i_io        (filt_reg[3:0]),
		.o_byte_stb  (byte_stb),
		.o_byte      (byte_val)
	);

	reg [1:0]  state_reg;
	reg [31:0] cnt_reg;
	reg [7:0]  op_reg;
	reg [7:0]  data_reg;
	reg [1:0]  nbytes_reg;
	reg        xip_frame_reg;
	reg        armed_reg;
	reg        exit_pend_reg;
	reg        drop_reg;

	wire [31:0] rst_last = RST_CYCLES - 1;
	wire        idle     = state_reg == ST_IDLE;

	// edge history of filtered pins
	always @(posedge i_mclk)
	begin
		if (i_rst)
		begin
			sclk_d_reg  <= 1'b0;
			frame_d_reg <= 1'b0;
		end
		else
		begin
			sclk_d_reg  <= filt_reg[5];
			frame_d_reg <= frame;
		end
	end

	// byte capture; a frame opened while busy is discarded whole
	always @(posedge i_mclk)
	begin
		if (i_rst)
		begin
			op_reg        <= 8'h00;
			data_reg      <= 8'h00;
			nbytes_reg    <= 2'h0;
			xip_frame_reg <= 1'b0;
			drop_reg      <= 1'b0;
		end
		else if (frame && !frame_d_reg)
		begin
			op_reg        <= 8'h00;
			data_reg      <= 8'h00;
			nbytes_reg    <= 2'h0;
			xip_frame_reg <= o_xip;
			// late bytes of such a frame would pose as an opcode
			drop_reg      <= o_busy;
		end
		else if (byte_stb && idle && !drop_reg)
		begin
			if (nbytes_reg == 2'h0)
				op_reg <= byte_val;
			if (nbytes_reg == 2'h1)
				data_reg <= byte_val;
			if (nbytes_reg != 2'h3)
				nbytes_reg <= nbytes_reg + 2'h1;
		end
	end

	// in 0-4-4 mode the first byte is address, never an opcode
	wire cmd_done = frame_end && idle && !xip_frame_reg && nbytes_reg != 2'h0;
	wire single   = nbytes_reg == 2'h1;

	// command execution and reset sequencing
	always @(posedge i_mclk)
	begin
		if (i_rst)
		begin
			state_reg     <= ST_LOAD;
			cnt_reg       <= 32'h0;
			armed_reg     <= 1'b0;
			o_param_dword <= 32'h0;
			o_sr1         <= 8'h00;
			o_wel         <= 1'b0;
			o_vwel        <= 1'b0;
			o_nv_write    <= 1'b0;
			o_nv_data     <= 8'h00;
			o_soft_reset  <= 1'b0;
			o_busy        <= 1'b1;
			o_cmd_stb     <= 1'b0;
			o_cmd_code    <= 8'h00;
		end
		else
		begin
			o_nv_write   <= 1'b0;
			o_soft_reset <= 1'b0;
			o_cmd_stb    <= 1'b0;
			// fixed capability fields
			o_param_dword <= {`PT_ENTER_4B, `PT_EXIT_4B,
				`PT_SOFT_RESET, `PT_RFU_BIT7, `PT_SR1_WREN};
			case (state_reg)
				ST_LOAD:
				begin
					// volatile copy taken from stored value after reset
					o_sr1     <= {i_nv_sr1[7:2], 2'b00};
					o_wel     <= 1'b0;
					o_vwel    <= 1'b0;
					armed_reg <= 1'b0;
					o_busy    <= 1'b0;
					state_reg <= ST_IDLE;
				end
				ST_IDLE:
				begin
					if (cmd_done)
					begin
						// anything but a lone 66h byte leaves reset disarmed
						armed_reg <= single && op_reg == `OP_RESET_ENABLE;
						if (single && op_reg == `OP_RESET && armed_reg)
						begin
							o_soft_reset <= 1'b1;
							o_busy       <= 1'b1;
							cnt_reg      <= 32'h0;
							state_reg    <= ST_RST;
						end
						else if (single && op_reg == `OP_WRITE_ENABLE)
							o_wel <= 1'b1;
						else if (single && op_reg == `OP_VOL_WR_ENABLE)
							o_vwel <= 1'b1;
						else if (op_reg == `OP_WRITE_STATUS && !single)
						begin
							if (o_vwel)
							begin
								// volatile only, stored copy untouched
								o_sr1[`SR1_WR_MSB:`SR1_WR_LSB] <=
									data_reg[`SR1_WR_MSB:`SR1_WR_LSB];
								o_vwel <= 1'b0;
							end
							else if (o_wel)
							begin
								o_sr1[`SR1_WR_MSB:`SR1_WR_LSB] <=
									data_reg[`SR1_WR_MSB:`SR1_WR_LSB];
								o_nv_write <= 1'b1;
								o_nv_data  <= {data_reg[7:2], 2'b00};
								o_wel      <= 1'b0;
							end
						end
						else if (op_reg != `OP_RESET_ENABLE &&
							op_reg != `OP_RESET)
						begin
							o_cmd_stb  <= 1'b1;
							o_cmd_code <= op_reg;
						end
					end
				end
				ST_RST:
				begin
					// no command taken until the count runs out
					if (cnt_reg >= rst_last)
						state_reg <= ST_LOAD;
					else
						cnt_reg <= cnt_reg + 32'h1;
				end
				default:
					state_reg <= ST_LOAD;
			endcase
		end
	end

	// continuous 0-4-4 mode, steered by mode bits of each read
	always @(posedge i_mclk)
	begin
		if (i_rst || o_soft_reset)
		begin
			o_xip         <= 1'b0;
			exit_pend_reg <= 1'b1;
		end
		else
		begin
			if (i_mode_bits_stb)
				exit_pend_reg <= i_mode_bits != `MODE_BITS_STAY;
			// mode ends only when the current read finishes
			if (i_read_done)
				o_xip <= !(i_mode_bits_stb ?
					i_mode_bits != `MODE_BITS_STAY : exit_pend_reg);
		end
	end

endmodule // flash_reset_ctrl

// *** test/flash_reset_ctrl_assertions.sv ***
`timescale 1ns/10ps
module flash_reset_ctrl_chk
#(
	parameter RST_CYCLES = 1000
)
(
	// clock and reset
	input wire        i_mclk,
	input wire        i_rst,
	// watched inputs
	input wire [7:0]  i_nv_sr1,
	input wire        i_read_done,
	// watched outputs
	input wire [31:0] o_param_dword,
	input wire [7:0]  o_sr1,
	input wire        o_wel,
	input wire        o_vwel,
	input wire        o_nv_write,
	input wire [7:0]  o_nv_data,
	input wire        o_soft_reset,
	input wire        o_busy,
	input wire        o_xip,
	input wire        o_cmd_stb
);
	reg [15:0] busy_cnt;
	reg        from_soft;
	default clocking cb @(posedge i_mclk); endclocking
	default disable iff (i_rst);
	// busy length, only judged after a software reset
	always @(posedge i_mclk)
	begin
		busy_cnt <= o_busy ? busy_cnt + 16'h1 : 16'h0;
		from_soft <= !i_rst && (o_soft_reset || (from_soft && o_busy));
	end
	property p_param;
		!$past(i_rst) |-> o_param_dword == 32'h80C030E8;
	endproperty
	a_param: assert property (p_param) else $error("param");
	property p_rise;
		$rose(o_busy) |-> o_soft_reset;
	endproperty
	a_rise: assert property (p_rise) else $error("busy cause");
	property p_len;
		$fell(o_busy) && from_soft |->
			busy_cnt >= RST_CYCLES && busy_cnt <= RST_CYCLES + 4;
	endproperty
	a_len: assert property (p_len) else $error("busy length");
	property p_load;
		$fell(o_busy) |-> o_sr1 == ($past(i_nv_sr1) & 8'hFC) && !o_wel;
	endproperty
	a_load: assert property (p_load) else $error("reload");
	property p_nv;
		o_nv_write |-> $past(o_wel) && !o_wel && o_nv_data[1:0] == 2'h0;
	endproperty
	a_nv: assert property (p_nv) else $error("nv write");
	property p_vol;
		$fell(o_vwel) && !o_busy |-> !o_nv_write;
	endproperty
	a_vol: assert property (p_vol) else $error("vol write");
	property p_quiet;
		o_busy |-> !o_cmd_stb && !o_nv_write;
	endproperty
	a_quiet: assert property (p_quiet) else $error("busy cmd");
	property p_xip;
		$changed(o_xip) |-> $past(i_read_done) || o_busy || $past(o_busy);
	endproperty
	a_xip: assert property (p_xip) else $error("xip");
endmodule // flash_reset_ctrl_chk

bind flash_reset_ctrl flash_reset_ctrl_chk #(.RST_CYCLES(RST_CYCLES)) u_chk
(
	.i_mclk(i_mclk), .i_rst(i_rst), .i_nv_sr1(i_nv_sr1),
	.i_read_done(i_read_done), .o_param_dword(o_param_dword),
	.o_sr1(o_sr1), .o_wel(o_wel), .o_vwel(o_vwel),
	.o_nv_write(o_nv_write), .o_nv_data(o_nv_data),
	.o_soft_reset(o_soft_reset), .o_busy(o_busy), .o_xip(o_xip),
	.o_cmd_stb(o_cmd_stb)
);

// *** test/spi_host_model.sv ***
`timescale 1ns/10ps
module spi_host_model
(
	// serial pins toward the flash
	input  wire       i_mclk,
	output reg        o_sclk,
	output reg        o_cs_n,
	output reg  [3:0] o_io
);
	integer k;
	initial {o_sclk, o_cs_n, o_io} = 6'h10;
	// mode 0 frame, msb first, four mclk per sclk phase
	task frame(input [15:0] d, input integer nb, input [1:0] w);
		integer    s;
		reg [19:0] t;
		begin
			s = 1 << w;
			t = {d, 4'h0};
			@(negedge i_mclk);
			o_cs_n = 1'b0;
			for (k = 0; k < nb * 8; k = k + s)
			begin
				o_io = t[19 - k -: 4] >> (4 - s);
				repeat (4) @(negedge i_mclk);
				o_sclk = 1'b1;
				repeat (4) @(negedge i_mclk);
				o_sclk = 1'b0;
			end
			repeat (4) @(negedge i_mclk);
			o_cs_n = 1'b1;
			o_io = ~o_io; // released lines do not keep the last bit
			repeat (12) @(negedge i_mclk);
		end
	endtask
endmodule // spi_host_model

// *** test/flash_reset_and_sr1_write_enable_tb_top.sv ***
`timescale 1ns/10ps
`include "flash_reset_defs.vh"
module flash_reset_and_sr1_write_enable_tb_top;
	reg         i_mclk = 1'b0;
	reg         i_rst = 1'b1;
	reg  [1:0]  width = 2'h0;
	reg         mstb = 1'b0;
	reg  [7:0]  mbits = 8'h00;
	reg         rdone = 1'b0;
	reg  [7:0]  exp_nv = 8'hB7;
	wire        sclk, cs_n, wel, vwel, nvw, srst, busy, xip, cstb;
	wire [3:0]  io;
	wire [7:0]  sr1, nvd, ccode;
	wire [31:0] pdw;
	integer     failures = 0, checked = 0, rcnt = 0, ncnt = 0, n, k;
	integer     ccnt = 0, c;
	always #5 i_mclk = ~i_mclk;
	spi_host_model i_host (.i_mclk(i_mclk), .o_sclk(sclk), .o_cs_n(cs_n),
		.o_io(io));
	flash_reset_ctrl #(.RST_CYCLES(40)) i_dut (.i_mclk(i_mclk),
		.i_rst(i_rst), .i_sclk(sclk), .i_cs_n(cs_n), .i_io(io),
		.i_width(width), .i_nv_sr1(exp_nv), .i_mode_bits_stb(mstb),
		.i_mode_bits(mbits), .i_read_done(rdone), .o_param_dword(pdw),
		.o_sr1(sr1), .o_wel(wel), .o_vwel(vwel), .o_nv_write(nvw),
		.o_nv_data(nvd), .o_soft_reset(srst), .o_busy(busy), .o_xip(xip),
		.o_cmd_stb(cstb), .o_cmd_code(ccode));
	// one-cycle pulses are counted, a later look would miss them
	always @(posedge i_mclk)
	begin
		rcnt = rcnt + (srst === 1'b1);
		ncnt = ncnt + (nvw === 1'b1);
		ccnt = ccnt + (cstb === 1'b1);
	end
	task chk(input ok);
	begin
		checked = checked + 1;
		if (ok !== 1'b1)
		begin
			failures = failures + 1;
			$display("[ERR] %0t mismatch", $time);
		end
	end
	endtask
	task f(input [7:0] a, input [7:0] b, input integer nb);
		i_host.frame({a, b}, nb, width);
	endtask
	task idle;
		for (k = 0; k < 300 && busy !== 1'b0; k = k + 1)
			@(negedge i_mclk);
	endtask
	task mode(input [7:0] m);
	begin
		mbits = m;
		mstb = 1'b1;
		@(negedge i_mclk);
		mstb = 1'b0;
		rdone = 1'b1;
		@(negedge i_mclk);
		rdone = 1'b0;
		repeat (2) @(negedge i_mclk);
	end
	endtask
	task t_reset(input [1:0] w);
	begin
		width = w;
		n = rcnt;
		f(`OP_RESET_ENABLE, 8'h00, 1);
		f(`OP_RESET, 8'h00, 1);
		chk(rcnt === n + 1 && busy === 1'b1);
		if (w == 2'h2)
			f(`OP_WRITE_ENABLE, 8'h00, 1);
		idle;
		chk(sr1 === {exp_nv[7:2], 2'h0} && wel === 1'b0);
	end
	endtask
	task t_status;
	begin
		n = ncnt;
		f(`OP_WRITE_STATUS, 8'hFF, 2);
		chk(sr1 === 8'hB4 && ncnt === n);
		f(`OP_WRITE_ENABLE, 8'h00, 1);
		chk(wel === 1'b1);
		f(`OP_WRITE_STATUS, 8'h5F, 2);
		chk(sr1 === 8'h5C && nvd === 8'h5C && ncnt === n + 1);
		exp_nv = 8'h5C;
		f(`OP_VOL_WR_ENABLE, 8'h00, 1);
		chk(vwel === 1'b1);
		f(`OP_WRITE_STATUS, 8'hA3, 2);
		chk(sr1 === 8'hA0 && ncnt === n + 1 && vwel === 1'b0);
	end
	endtask
	task t_disarm;
	begin
		n = rcnt;
		f(`OP_RESET_ENABLE, 8'h00, 1);
		f(`OP_WRITE_ENABLE, 8'h00, 1);
		f(`OP_RESET, 8'h00, 1);
		chk(rcnt === n && busy === 1'b0);
		c = ccnt;
		f(`OP_RESET_ENABLE, 8'h00, 1);
		f(8'h3C, 8'h00, 1);
		f(`OP_RESET, 8'h00, 1);
		chk(rcnt === n && ccnt === c + 1 && ccode === 8'h3C);
	end
	endtask
	task t_xip;
	begin
		mode(`MODE_BITS_STAY);
		chk(xip === 1'b1);
		n = rcnt;
		f(`OP_RESET_ENABLE, 8'h00, 1);
		f(`OP_RESET, 8'h00, 1);
		chk(rcnt === n);
		mode(`MODE_BITS_EXIT);
		chk(xip === 1'b0);
		t_reset(2'h2);
	end
	endtask
	task give_verdict;
	begin
		$display("checked %0d failures %0d", checked, failures);
		if (failures == 0 && checked > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	end
	endtask
	// main sequence
	initial
	begin
		repeat (2) @(negedge i_mclk);
		i_rst = 1'b0;
		idle;
		repeat (4) @(negedge i_mclk);
		chk(pdw === 32'h80C030E8);
		chk(sr1 === 8'hB4);
		t_reset(2'h0);
		t_status;
		t_reset(2'h1);
		t_disarm;
		t_xip;
		give_verdict;
	end
	// watchdog, far beyond the roughly 1500 cycles needed
	initial
	begin
		#100000;
		failures = failures + 1;
		give_verdict;
	end
endmodule // flash_reset_and_sr1_write_enable_tb_top
